// ---- inc/drp_pkg.sv ----
`default_nettype none
package drp_pkg;
  // Wake timer period selector
  typedef enum logic [1:0] {
    DRP_PER_1MS,
    DRP_PER_16MS,
    DRP_PER_64MS,
    DRP_PER_128MS
  } drp_period_t;
  // Halt state of the core as seen by this block
  typedef enum logic {
    DRP_RUN,
    DRP_HALTED
  } drp_run_t;
endpackage
`default_nettype wire

// ---- inc/drp_regs.svh ----
`ifndef DRP_REGS_SVH
`define DRP_REGS_SVH
// Register addresses on the nibble SFR port
`define DRP_ADDR_WAKE_CTRL  8'h16
`define DRP_ADDR_NIB0       8'h18
`define DRP_ADDR_NIB1       8'h19
`define DRP_ADDR_NIB2       8'h1a
`define DRP_ADDR_NIB3       8'h1b
`define DRP_ADDR_DATA_LOW   8'h1c
`define DRP_ADDR_DATA_HIGH  8'h1d
`define DRP_ADDR_TOP        8'h1e
// Wake timer control field positions
`define DRP_WT_FLAG_BIT     3
`define DRP_WT_EN_BIT       2
`define DRP_WT_SEL_HI       1
`define DRP_WT_SEL_LO       0
`define DRP_WT_CTRL_RESET   4'h0
// Value written to the high-data register that clears the wake timer
`define DRP_WT_CLEAR_VALUE  4'ha
// Wake timer periods in milliseconds
`define DRP_WT_MS_SEL0      1
`define DRP_WT_MS_SEL1      16
`define DRP_WT_MS_SEL2      64
`define DRP_WT_MS_SEL3      128
// System clock rate in kHz
`define DRP_CLK_KHZ         25000
// Data ready time in clock periods
`define DRP_READY_CYCLES    2
`endif

// ---- logic/drp_data_rom_port.sv ----
`include "drp_regs.svh"
`default_nettype none
// Operation
// R1: Five address nibbles form a 20-bit address
// R2: Lowest location is least significant nibble
// R3: Only bit 0 of top register exists
// R4: Low-data read returns ROM bits 3..0
// R5: High-data read returns ROM bits 7..4
// R6: Core waits ready delay before data reads
// R7: Data valid within two clocks of write
// R8: High-data write clears enabled watchdog
// R9: Writing value A clears wake timer
// R10: Software avoids last 64 reserved locations
// R11: No range checking on reserved area
// R12: Each location holds one 8-bit byte
// R13: Wake timer overflow wakes halted core to 004h
// R14: Overflow flag set by hardware, cleared by software
// R15: Enable bit runs or stops wake timer
// R16: Period select picks 128/64/16/1 ms
// R17: Data writes leave ROM; address readback works
module drp_data_rom_port
  import drp_pkg::*;
#(
  parameter int          ADDR_W   = 17,                      // Implemented ROM address bits
  parameter int          DEPTH    = 67584,                   // ROM locations (66K bytes)
  parameter int unsigned MS_CYC   = `DRP_CLK_KHZ,            // Clocks per millisecond
  parameter int unsigned WDT_LEN  = 1048576,                 // Watchdog length in clocks
  parameter logic [19:0] WAKE_VEC = 20'h00004                // Wake-up vector
) (
  input  wire logic        clk,             // System clock, 25 MHz
  input  wire logic        rst,             // Synchronous reset, active high
  input  wire logic        sfr_wr,          // Core register write strobe
  input  wire logic        sfr_rd,          // Core register read strobe
  input  wire logic [7:0]  sfr_addr,        // Register address
  input  wire logic [3:0]  sfr_wdata,       // Write nibble
  input  wire logic        wdt_option,      // Watchdog enabled by option
  input  wire logic        core_halted,     // Core is in halt mode
  output logic      [3:0]  sfr_rdata,       // Read nibble, registered
  output logic             wdt_reset,       // Watchdog overflow reset pulse
  output logic             wake_req,        // Wake request pulse to core
  output logic      [19:0] wake_vector      // Resume address for the wake
);

  // Mask ROM contents, loaded by the mask, zeroed at time zero, then only read here
  logic [7:0]        data_rom [DEPTH];
  // Address nibbles
  logic [3:0]        rom_addr_nib0_reg;      // Least significant nibble
  logic [3:0]        rom_addr_nib1_reg;      // Second nibble
  logic [3:0]        rom_addr_nib2_reg;      // Third nibble
  logic [3:0]        rom_addr_nib3_reg;      // Fourth nibble
  logic              rom_addr_top_reg;       // Only implemented top bit
  logic [19:0]       rom_addr;               // Full 20-bit address
  logic [7:0]        rom_byte_reg;           // Byte fetched from the ROM
  // Wake timer control
  logic              wake_timer_overflow_flag_reg; // Sticky overflow flag
  logic              wake_timer_enable_reg;        // Timer run enable
  drp_period_t       wake_timer_period_sel_reg;    // Period select
  logic [31:0]       wake_cnt_reg;                 // Wake timer counter
  logic [31:0]       wake_limit;                   // Terminal count
  logic              wake_ovf;                     // Overflow this cycle
  // Watchdog
  logic [31:0]       watchdog_counter_reg;         // Watchdog counter
  logic [3:0]        rd_next;                      // Read mux output

  // Write and clear decodes
  logic wr_high;
  logic wr_ctrl;
  assign wr_high = sfr_wr && (sfr_addr == `DRP_ADDR_DATA_HIGH);
  assign wr_ctrl = sfr_wr && (sfr_addr == `DRP_ADDR_WAKE_CTRL);

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      data_rom[i] = 8'h00;
    end
  end

  // Nibble concatenation of the read address
  assign rom_addr = {3'h0, rom_addr_top_reg, rom_addr_nib3_reg, rom_addr_nib2_reg,
                     rom_addr_nib1_reg, rom_addr_nib0_reg}; // R1 R2 R3

  // Address register writes; reset gives a known address so reads below DEPTH never see X
  always_ff @(posedge clk) begin
    if (rst) begin
      rom_addr_nib0_reg <= 4'h0; // Known start address
      rom_addr_nib1_reg <= 4'h0;
      rom_addr_nib2_reg <= 4'h0;
      rom_addr_nib3_reg <= 4'h0;
      rom_addr_top_reg  <= 1'b0;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `DRP_ADDR_NIB0: begin
          rom_addr_nib0_reg <= sfr_wdata; // R2
        end
        `DRP_ADDR_NIB1: begin
          rom_addr_nib1_reg <= sfr_wdata;
        end
        `DRP_ADDR_NIB2: begin
          rom_addr_nib2_reg <= sfr_wdata;
        end
        `DRP_ADDR_NIB3: begin
          rom_addr_nib3_reg <= sfr_wdata;
        end
        `DRP_ADDR_TOP: begin
          rom_addr_top_reg <= sfr_wdata[0]; // R3
        end
        default: begin
          // Data-low writes fall here and change nothing
        end
      endcase
    end
  end

  // ROM fetch one clock after the address settles, no range check
  always_ff @(posedge clk) begin
    rom_byte_reg <= data_rom[rom_addr[ADDR_W-1:0]]; // R7 R11 R12
  end

  // Read mux
  always_comb begin
    rd_next = 4'h0;
    case (sfr_addr)
      `DRP_ADDR_NIB0:      rd_next = rom_addr_nib0_reg; // R17
      `DRP_ADDR_NIB1:      rd_next = rom_addr_nib1_reg;
      `DRP_ADDR_NIB2:      rd_next = rom_addr_nib2_reg;
      `DRP_ADDR_NIB3:      rd_next = rom_addr_nib3_reg;
      `DRP_ADDR_TOP:       rd_next = {3'h0, rom_addr_top_reg};
      `DRP_ADDR_DATA_LOW:  rd_next = rom_byte_reg[3:0]; // R4
      `DRP_ADDR_DATA_HIGH: rd_next = rom_byte_reg[7:4]; // R5
      `DRP_ADDR_WAKE_CTRL: rd_next = {wake_timer_overflow_flag_reg, wake_timer_enable_reg,
                                      wake_timer_period_sel_reg};
      default:             rd_next = 4'h0;
    endcase
  end

  // Registered read data
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= 4'h0;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_next;
    end
  end

  // Wake timer terminal count per period
  always_comb begin
    case (wake_timer_period_sel_reg)
      DRP_PER_128MS: wake_limit = 32'(`DRP_WT_MS_SEL3 * MS_CYC); // R16
      DRP_PER_64MS:  wake_limit = 32'(`DRP_WT_MS_SEL2 * MS_CYC);
      DRP_PER_16MS:  wake_limit = 32'(`DRP_WT_MS_SEL1 * MS_CYC);
      default:       wake_limit = 32'(`DRP_WT_MS_SEL0 * MS_CYC);
    endcase
  end
  assign wake_ovf = wake_timer_enable_reg && (wake_cnt_reg >= wake_limit - 32'h1);

  // Wake timer control register; overflow set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_timer_overflow_flag_reg <= 1'(`DRP_WT_CTRL_RESET >> `DRP_WT_FLAG_BIT);
      wake_timer_enable_reg        <= 1'b0;
      wake_timer_period_sel_reg    <= DRP_PER_1MS;
    end else begin
      if (wr_ctrl) begin
        wake_timer_enable_reg     <= sfr_wdata[`DRP_WT_EN_BIT]; // R15
        wake_timer_period_sel_reg <= drp_period_t'(sfr_wdata[`DRP_WT_SEL_HI:`DRP_WT_SEL_LO]);
        if (!sfr_wdata[`DRP_WT_FLAG_BIT]) begin
          wake_timer_overflow_flag_reg <= 1'b0; // R14
        end
      end
      if (wake_ovf) begin
        wake_timer_overflow_flag_reg <= 1'b1; // R14
      end
    end
  end

  // Wake timer counter
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_cnt_reg <= 32'h0;
    end else if (wr_high && sfr_wdata == `DRP_WT_CLEAR_VALUE) begin
      wake_cnt_reg <= 32'h0; // R9
    end else if (!wake_timer_enable_reg || wake_ovf) begin
      wake_cnt_reg <= 32'h0; // R15
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 32'h1;
    end
  end

  // Wake request to a halted core
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req    <= 1'b0;
      wake_vector <= WAKE_VEC;
    end else begin
      wake_req    <= wake_ovf && core_halted; // R13
      wake_vector <= WAKE_VEC;
    end
  end

  // Watchdog counter
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdog_counter_reg <= 32'h0;
      wdt_reset            <= 1'b0;
    end else if (!wdt_option || wr_high) begin
      watchdog_counter_reg <= 32'h0; // R8
      wdt_reset            <= 1'b0;
    end else if (watchdog_counter_reg >= WDT_LEN - 1) begin
      watchdog_counter_reg <= 32'h0;
      wdt_reset            <= 1'b1;
    end else begin
      watchdog_counter_reg <= watchdog_counter_reg + 32'h1;
      wdt_reset            <= 1'b0;
    end
  end

  // Data valid two clocks after the last address write
  ready_time_a: assert property (@(posedge clk) disable iff (rst) // R7
    (sfr_wr && sfr_addr == `DRP_ADDR_NIB0) ##1 !sfr_wr |=>
      rom_byte_reg == data_rom[rom_addr[ADDR_W-1:0]])
    else $error("ROM byte not ready in two clocks");
  // Low read returns byte low nibble
  low_read_a: assert property (@(posedge clk) disable iff (rst) // R4
    sfr_rd && sfr_addr == `DRP_ADDR_DATA_LOW |=> sfr_rdata == $past(rom_byte_reg[3:0]))
    else $error("Low nibble mismatch");
  // High read returns byte high nibble
  high_read_a: assert property (@(posedge clk) disable iff (rst) // R5
    sfr_rd && sfr_addr == `DRP_ADDR_DATA_HIGH |=> sfr_rdata == $past(rom_byte_reg[7:4]))
    else $error("High nibble mismatch");
  // Top nibble keeps one bit
  top_bit_a: assert property (@(posedge clk) disable iff (rst) // R3
    sfr_rd && sfr_addr == `DRP_ADDR_TOP |=> sfr_rdata[3:1] == 3'h0)
    else $error("Top address upper bits not zero");
  // Watchdog clears on high write
  wdt_clear_a: assert property (@(posedge clk) disable iff (rst) // R8
    wr_high |=> watchdog_counter_reg == 32'h0 && !wdt_reset)
    else $error("Watchdog not cleared");
  // Wake timer cleared by value A
  wake_clear_a: assert property (@(posedge clk) disable iff (rst) // R9
    wr_high && sfr_wdata == `DRP_WT_CLEAR_VALUE |=> wake_cnt_reg == 32'h0)
    else $error("Wake counter not cleared");
  // Overflow flag sticks
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // R14
    wake_ovf |=> wake_timer_overflow_flag_reg)
    else $error("Overflow flag not set");
  // Halted core woken on overflow
  wake_pulse_a: assert property (@(posedge clk) disable iff (rst) // R13
    wake_ovf && core_halted |=> wake_req && wake_vector == WAKE_VEC)
    else $error("Wake request missing");
  // Stopped timer does not count
  timer_stop_a: assert property (@(posedge clk) disable iff (rst) // R15
    !wake_timer_enable_reg |=> wake_cnt_reg == 32'h0)
    else $error("Disabled timer counted");

  // Lowest address nibble follows its write
  addr_low_a: assert property (@(posedge clk) disable iff (rst) // R2
    sfr_wr && sfr_addr == `DRP_ADDR_NIB0 |=>
      rom_addr[3:0] == $past(sfr_wdata))
    else $error("Low address nibble not written");

  // Second nibble lands in address bits 7..4
  addr_mid_a: assert property (@(posedge clk) disable iff (rst) // R1
    sfr_wr && sfr_addr == `DRP_ADDR_NIB1 |=>
      rom_addr[7:4] == $past(sfr_wdata))
    else $error("Second address nibble misplaced");

  // Top register keeps only its lowest bit
  addr_top_a: assert property (@(posedge clk) disable iff (rst) // R3
    sfr_wr && sfr_addr == `DRP_ADDR_TOP |=>
      rom_addr[19:16] == {3'h0, $past(sfr_wdata[0])})
    else $error("Top address bits wrong");

  // Data-low writes leave the address alone
  low_write_a: assert property (@(posedge clk) disable iff (rst) // R17
    sfr_wr && sfr_addr == `DRP_ADDR_DATA_LOW |=>
      $stable(rom_addr))
    else $error("Data write moved the address");

  // Address readback returns the stored nibble
  nib_readback_a: assert property (@(posedge clk) disable iff (rst) // R17
    sfr_rd && sfr_addr == `DRP_ADDR_NIB0 |=>
      sfr_rdata == $past(rom_addr_nib0_reg))
    else $error("Address readback wrong");

  // Read data holds between reads
  rdata_hold_a: assert property (@(posedge clk) disable iff (rst) // R4
    !sfr_rd |=>
      $stable(sfr_rdata))
    else $error("Read data changed without a read");

  // Enable bit follows its write
  enable_write_a: assert property (@(posedge clk) disable iff (rst) // R15
    wr_ctrl |=>
      wake_timer_enable_reg == $past(sfr_wdata[`DRP_WT_EN_BIT]))
    else $error("Timer enable not written");

  // Period select follows its write
  period_write_a: assert property (@(posedge clk) disable iff (rst) // R16
    wr_ctrl |=>
      wake_timer_period_sel_reg == $past(sfr_wdata[1:0]))
    else $error("Period select not written");

  // Running timer counts one per clock
  wake_count_a: assert property (@(posedge clk) disable iff (rst) // R15
    wake_timer_enable_reg && !wake_ovf && !wr_high |=>
      wake_cnt_reg == $past(wake_cnt_reg) + 32'h1)
    else $error("Wake timer did not count");

  // Overflow restarts the period
  ovf_restart_a: assert property (@(posedge clk) disable iff (rst) // R16
    wake_ovf |=>
      wake_cnt_reg == 32'h0)
    else $error("Wake timer not restarted");

  // Writing zero to the flag clears it
  flag_clear_a: assert property (@(posedge clk) disable iff (rst) // R14
    wr_ctrl && !sfr_wdata[`DRP_WT_FLAG_BIT] && !wake_ovf |=>
      !wake_timer_overflow_flag_reg)
    else $error("Overflow flag not cleared");

  // Flag holds without write or overflow
  flag_hold_a: assert property (@(posedge clk) disable iff (rst) // R14
    !wr_ctrl && !wake_ovf |=>
      $stable(wake_timer_overflow_flag_reg))
    else $error("Overflow flag changed by itself");

  // No wake request without a halted overflow
  wake_quiet_a: assert property (@(posedge clk) disable iff (rst) // R13
    !(wake_ovf && core_halted) |=>
      !wake_req)
    else $error("Spurious wake request");

  // Watchdog idle while not enabled by option
  wdt_off_a: assert property (@(posedge clk) disable iff (rst) // R8
    !wdt_option |=>
      watchdog_counter_reg == 32'h0 && !wdt_reset)
    else $error("Disabled watchdog ran");

  // Enabled watchdog counts until kicked
  wdt_count_a: assert property (@(posedge clk) disable iff (rst) // R8
    wdt_option && !wr_high && watchdog_counter_reg < WDT_LEN - 1 |=>
      watchdog_counter_reg == $past(watchdog_counter_reg) + 32'h1)
    else $error("Watchdog did not count");

endmodule
`default_nettype wire

// ---- verif/drp_core_model.sv ----
`default_nettype none
// Core side model: one register load per call
module drp_core_model (
  input  wire logic       clk,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_addr,
  output logic      [3:0] sfr_wdata,
  input  wire logic [3:0] sfr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 4'h0;
  end
  // Write strobe held for one edge
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk) #1;
    sfr_wr = 1'b0;
  endtask
  // Read strobe; data lands on the taking edge
  task automatic rd(input logic [7:0] a, output logic [3:0] d);
    @(posedge clk) #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk) #1;
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  // Next read is taken three edges after the last address write
  task automatic settle;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`include "drp_regs.svh"
`default_nettype none
module testbench;
  import drp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;  // Shortened clocks per millisecond
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wdt_option = 1'b0;
  logic        core_halted = 1'b0;
  logic        sfr_wr, sfr_rd, wdt_reset, wake_req;
  logic [7:0]  sfr_addr;
  logic [3:0]  sfr_wdata, sfr_rdata, d;
  logic [19:0] wake_vector;
  int          error_cnt = 0, comparisons = 0, cyc = 0, n;
  always #20 clk = ~clk;
  drp_data_rom_port #(.MS_CYC(MS), .WDT_LEN(64)) dut (.clk(clk), .rst(rst),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .wdt_option(wdt_option), .core_halted(core_halted), .sfr_rdata(sfr_rdata),
    .wdt_reset(wdt_reset), .wake_req(wake_req), .wake_vector(wake_vector));
  drp_core_model core (.clk(clk), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
  // Verdict and end of run
  task automatic results;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Cycles until a pulse (1 = watchdog, 0 = wake), capped at m
  task automatic wait_sig(input bit w, input int m, output int c);
    c = 0;
    do begin
      @(posedge clk) #1;
      c++;
    end while ((w ? wdt_reset : wake_req) !== 1'b1 && c < m);
  endtask
  // Bytes read back through both data nibbles
  task automatic t_rom;
    logic [16:0] a [4] = '{17'h107ff, 17'h107bf, 17'h00000, 17'h0a5c3};
    logic [7:0]  b [4] = '{8'h5a, 8'h3c, 8'h81, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      dut.data_rom[a[i]] = b[i];
      for (int k = 0; k < 4; k++) core.wr(8'(`DRP_ADDR_NIB0 + k), a[i][4*k+:4]);
      core.wr(`DRP_ADDR_TOP, {3'b111, a[i][16]});
      core.settle();
      core.rd(`DRP_ADDR_DATA_LOW, d);
      chk("low", 20'(b[i][3:0]), 20'(d));
      core.rd(`DRP_ADDR_DATA_HIGH, d);
      chk("high", 20'(b[i][7:4]), 20'(d));
    end
  endtask
  // Readback, ignored data write, unmapped read
  task automatic t_regs;
    logic [3:0] e [4] = '{4'h3, 4'hc, 4'h5, 4'ha};
    core.wr(`DRP_ADDR_DATA_LOW, 4'h7);
    core.rd(`DRP_ADDR_DATA_LOW, d);
    chk("rom kept", 20'h3, 20'(d));
    for (int k = 0; k < 4; k++) begin
      core.rd(8'(`DRP_ADDR_NIB0 + k), d);
      chk("nib", 20'(e[k]), 20'(d));
    end
    core.rd(`DRP_ADDR_TOP, d);
    chk("top", 20'h0, 20'(d));
    core.rd(8'h17, d);
    chk("unmapped", 20'h0, 20'(d));
  endtask
  // Wake timer periods, flag, clear and stop
  task automatic t_wake;
    int ms [4] = '{`DRP_WT_MS_SEL0, `DRP_WT_MS_SEL1, `DRP_WT_MS_SEL2, `DRP_WT_MS_SEL3};
    core.rd(`DRP_ADDR_WAKE_CTRL, d);
    chk("ctrl rst", 20'(`DRP_WT_CTRL_RESET), 20'(d));
    core_halted = 1'b1;
    for (int s = 0; s < 4; s++) begin
      core.wr(`DRP_ADDR_WAKE_CTRL, {2'b01, 2'(s)});
      wait_sig(0, 1100, n);
      wait_sig(0, 1100, n);
      chk("period", 20'(ms[s] * MS), 20'(n));
    end
    chk("vector", 20'h00004, wake_vector);
    core.rd(`DRP_ADDR_WAKE_CTRL, d);
    chk("flag", 20'hf, 20'(d));
    core.wr(`DRP_ADDR_WAKE_CTRL, 4'h5);
    core.rd(`DRP_ADDR_WAKE_CTRL, d);
    chk("flag clr", 20'h5, 20'(d));
    wait_sig(0, 200, n);
    repeat (30) @(posedge clk);
    core.wr(`DRP_ADDR_DATA_HIGH, `DRP_WT_CLEAR_VALUE);
    wait_sig(0, 200, n);
    chk("wake clr", 20'h1, 20'(n > 50));
    core.wr(`DRP_ADDR_WAKE_CTRL, 4'h0);
    wait_sig(0, 600, n);
    chk("stopped", 20'd600, 20'(n));
  endtask
  // Watchdog kicked by high-data writes, only when enabled
  task automatic t_wdt;
    wdt_option = 1'b1;
    repeat (4) begin
      wait_sig(1, 40, n);
      chk("wdt kick", 20'd40, 20'(n));
      core.wr(`DRP_ADDR_DATA_HIGH, 4'h3);
    end
    wait_sig(1, 100, n);
    chk("wdt ovf", 20'h1, 20'(n < 70));
    wdt_option = 1'b0;
    wait_sig(1, 200, n);
    chk("wdt off", 20'd200, 20'(n));
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    chk("rdata rst", 20'h0, 20'(sfr_rdata));
    t_rom();
    t_regs();
    t_wake();
    t_wdt();
    results();
  end
endmodule
`default_nettype wire
